// ### hw/idl_pkg.sv
// Constants shared by the isolated digital I/O latch port
package idl_pkg;

  // ----------------------------------------------------------------
  // Channel counts
  // ----------------------------------------------------------------
  localparam int unsigned IN_CHANNELS  = 8;
  localparam int unsigned OUT_CHANNELS = 7;

  // ----------------------------------------------------------------
  // Host I/O address decode
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 10;
  localparam int unsigned BASE_W       = 5;
  localparam int unsigned BASE_LSB     = 4;
  localparam int unsigned BASE_MSB     = 8;
  localparam int unsigned RANGE_BIT    = 9;
  localparam int unsigned OFFS_LSB     = 2;
  localparam int unsigned OFFS_MSB     = 3;
  localparam logic [BASE_W-1:0] BASE_RESET = 5'h00;

  // ----------------------------------------------------------------
  // Register word offsets inside the 16-byte window
  // ----------------------------------------------------------------
  localparam logic [1:0] OFFS_POLARITY = 2'h0;
  localparam logic [1:0] OFFS_OUTPUT   = 2'h1;
  localparam logic [1:0] OFFS_INPUT    = 2'h2;
  localparam logic [1:0] OFFS_LATCH    = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  POLARITY_RESET = 8'h00;
  localparam logic [7:0]  OUTPUT_RESET   = 8'h00;
  localparam logic [7:0]  LATCH_RESET    = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

endpackage

// ### hw/idl_port.sv
// Isolated digital input latch port with open-collector outputs
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps

module idl_port #(
  parameter int unsigned IN_W  = idl_pkg::IN_CHANNELS,
  parameter int unsigned OUT_W = idl_pkg::OUT_CHANNELS
) (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          rstn,
  // Avalon-MM slave
  input  wire logic [idl_pkg::ADDR_W-1:0]    address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [3:0]                    byteenable,
  input  wire logic [31:0]                   writedata,
  output logic [31:0]                        readdata,
  output logic                               waitrequest,
  // Board base address strap
  input  wire logic [idl_pkg::BASE_W-1:0]    io_base_select,
  // Isolated inputs, raw pin levels
  input  wire logic [IN_W-1:0]               din,
  // Open-collector outputs
  output logic [OUT_W-1:0]                   dout_o,
  output logic [OUT_W-1:0]                   dout_oe_n
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [IN_W-1:0]                 din_meta_r;
  logic [IN_W-1:0]                 din_sync_r;
  logic [idl_pkg::BASE_W-1:0]      base_meta_r;
  logic [idl_pkg::BASE_W-1:0]      base_sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      din_meta_r  <= '0;
      din_sync_r  <= '0;
      base_meta_r <= idl_pkg::BASE_RESET;
      base_sync_r <= idl_pkg::BASE_RESET;
    end else begin
      din_meta_r  <= din;
      din_sync_r  <= din_meta_r;
      base_meta_r <= io_base_select;
      base_sync_r <= base_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]                      input_polarity_mask_r;
  logic [7:0]                      input_polarity_mask_nxt;
  logic [7:0]                      output_value_byte_r;
  logic [7:0]                      output_value_byte_nxt;
  logic [IN_W-1:0]                 latch_r;
  logic [IN_W-1:0]                 latch_nxt;
  logic [idl_pkg::BASE_W-1:0]      base_r;
  logic [idl_pkg::BASE_W-1:0]      base_nxt;
  logic [31:0]                     readdata_r;
  logic [31:0]                     readdata_nxt;
  logic                            waitrequest_r;
  logic                            waitrequest_nxt;
  logic [OUT_W-1:0]                dout_oe_n_r;
  logic [OUT_W-1:0]                dout_oe_n_nxt;

  // ----------------------------------------------------------------
  // Per-channel input qualification
  // ----------------------------------------------------------------
  logic [IN_W-1:0]                 input_value_byte;

  genvar ch;
  generate
    for (ch = 0; ch < IN_W; ch++) begin : g_chan
      assign input_value_byte[ch] = input_polarity_mask_r[ch] ? din_sync_r[ch]
                                                             : ~din_sync_r[ch];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Address decode and transfer strobes
  // ----------------------------------------------------------------
  logic                            hit;
  logic [1:0]                      offs;
  logic                            req_first;
  logic                            wr_commit;
  logic                            lane0;
  logic [7:0]                      wbyte;
  logic [7:0]                      latch_clear_mask;
  logic [7:0]                      rd_byte;

  // window sits inside 200h..3F0h, 16-byte aligned
  assign hit  = address[idl_pkg::RANGE_BIT] &&
                (address[idl_pkg::BASE_MSB:idl_pkg::BASE_LSB] == base_r);
  assign offs = address[idl_pkg::OFFS_MSB:idl_pkg::OFFS_LSB];

  // Request is first seen while waitrequest still stands high
  assign req_first = (read || write) && waitrequest_r;
  // A write takes effect only at the edge that raises waitrequest again
  assign wr_commit = write && !waitrequest_r && hit;
  assign lane0     = byteenable[0];
  assign wbyte     = writedata[7:0];
  assign latch_clear_mask = (wr_commit && lane0 && offs == idl_pkg::OFFS_LATCH)
                            ? wbyte : 8'h00;

  always_comb begin
    rd_byte = 8'h00;
    if (offs == idl_pkg::OFFS_POLARITY) begin
      rd_byte = input_polarity_mask_r;
    end else if (offs == idl_pkg::OFFS_OUTPUT) begin
      rd_byte = output_value_byte_r;
    end else if (offs == idl_pkg::OFFS_INPUT) begin
      rd_byte = input_value_byte;
    end else begin
      rd_byte = latch_r;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    input_polarity_mask_nxt = input_polarity_mask_r;
    output_value_byte_nxt   = output_value_byte_r;
    readdata_nxt            = readdata_r;
    waitrequest_nxt         = 1'b1;
    // Strap is followed continuously; it is expected to be static
    base_nxt                = base_sync_r;

    // One wait cycle, then a single-cycle acknowledge
    if (req_first) begin
      waitrequest_nxt = 1'b0;
      if (read && hit) begin
        readdata_nxt = {24'h00_0000, rd_byte};
      end else begin
        readdata_nxt = idl_pkg::UNMAPPED_DATA;
      end
    end

    if (wr_commit && lane0) begin
      if (offs == idl_pkg::OFFS_POLARITY) begin
        input_polarity_mask_nxt = wbyte;
      end else if (offs == idl_pkg::OFFS_OUTPUT) begin
        output_value_byte_nxt = wbyte;
      end
    end

    // active input sets latch; set beats clear
    latch_nxt = (latch_r & ~latch_clear_mask) | input_value_byte;

    // a 1 switches the sink on, enable is active low
    dout_oe_n_nxt = ~output_value_byte_nxt[OUT_W-1:0];
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      input_polarity_mask_r <= idl_pkg::POLARITY_RESET;
      output_value_byte_r   <= idl_pkg::OUTPUT_RESET;
      latch_r               <= idl_pkg::LATCH_RESET;
      base_r                <= idl_pkg::BASE_RESET;
      readdata_r            <= idl_pkg::UNMAPPED_DATA;
      waitrequest_r         <= 1'b1;
      dout_oe_n_r           <= '1;
    end else begin
      input_polarity_mask_r <= input_polarity_mask_nxt;
      output_value_byte_r   <= output_value_byte_nxt;
      latch_r               <= latch_nxt;
      base_r                <= base_nxt;
      readdata_r            <= readdata_nxt;
      waitrequest_r         <= waitrequest_nxt;
      dout_oe_n_r           <= dout_oe_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign readdata    = readdata_r;
  assign waitrequest = waitrequest_r;
  assign dout_oe_n   = dout_oe_n_r;
  // Open-collector: the driven level is always low
  assign dout_o      = '0;

endmodule

// ### test/idl_field.sv
// Field wiring: input levels and pulled-up output loads
`timescale 1ns/1ps
module idl_field (
  // From the port
  input wire logic [6:0] dout_o,
  input wire logic [6:0] dout_oe_n,
  // Bench side
  input wire logic [7:0] level,
  output logic     [7:0] din,
  output logic     [6:0] load_on
);
  assign din = level;
  // pulled-up load: a released line reads high, so its load is off
  assign load_on = ~(dout_oe_n | dout_o);
endmodule

// ### test/idl_port_assertions.sv
// Checker of bus answer, readback and output drive
`timescale 1ns/1ps
module idl_chk #(
  parameter int unsigned IN_W  = 8,
  parameter int unsigned OUT_W = 7
) (
  // Clock and reset
  input wire logic             clock,
  input wire logic             rstn,
  // Bus
  input wire logic [9:0]       address,
  input wire logic             read,
  input wire logic             write,
  input wire logic [3:0]       byteenable,
  input wire logic [31:0]      writedata,
  input wire logic [31:0]      readdata,
  input wire logic             waitrequest,
  // Pins
  input wire logic [4:0]       io_base_select,
  input wire logic [IN_W-1:0]  din,
  input wire logic [OUT_W-1:0] dout_o,
  input wire logic [OUT_W-1:0] dout_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Strap is static in use, so decode against its present value
  wire logic [9:0] base = {1'b1, io_base_select, 4'h0};
  wire logic       done = (read | write) & !waitrequest;
  wire logic [6:0] wd   = writedata[6:0];
  property p_ack; (read | write) && waitrequest |=> !waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("late answer");
  property p_one; !waitrequest |=> waitrequest; endproperty
  a_one: assert property (p_one) else $error("long answer");
  property p_oc; dout_o == '0; endproperty
  a_oc: assert property (p_oc) else $error("drive level");
  property p_do; done && write && byteenable[0] && address == base + 10'h4
    |=> dout_oe_n == ~$past(wd); endproperty
  a_do: assert property (p_do) else $error("output drive");
  property p_rb; done && read |=> $stable(dout_oe_n); endproperty
  a_rb: assert property (p_rb) else $error("readback moved pins");
  property p_hi; done |-> readdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper lanes");
  property p_un; read && waitrequest && address[9:4] != base[9:4] |=> readdata == 32'h0;
  endproperty
  a_un: assert property (p_un) else $error("unmapped read");
  property p_rs; $rose(rstn) |-> dout_oe_n == '1; endproperty
  a_rs: assert property (p_rs) else $error("outputs on at reset");
  cover property (done && write);
  cover property (done && read && address == base + 10'h8);
  cover property (read && !address[9]);
endmodule
bind idl_port idl_chk #(.IN_W(IN_W), .OUT_W(OUT_W)) u_chk (.*);

// ### test/test_isolated_dio_latch_port.sv
// Self-checking bench for the digital I/O latch port
`timescale 1ns/1ps
module test_isolated_dio_latch_port;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [9:0]  address = 10'h000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  be = 4'h1;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [4:0]  io_base_select = 5'h1F;
  logic [7:0]  level = 8'h00;
  logic [7:0]  din;
  logic [6:0]  dout_o;
  logic [6:0]  dout_oe_n;
  logic [6:0]  load_on;
  logic [31:0] rd;
  int          fail_count = 0;
  int          checked = 0;
  always #50 clock = ~clock;
  idl_port u_dut (.clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
    .byteenable(be), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .io_base_select(io_base_select), .din(din), .dout_o(dout_o), .dout_oe_n(dout_oe_n));
  idl_field u_field (.dout_o(dout_o), .dout_oe_n(dout_oe_n), .level(level), .din(din),
    .load_on(load_on));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then one idle edge
  task automatic acc(input logic wr, input logic [9:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h0, d};
    read <= !wr;
    write <= wr;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    summarize;
  end
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    rdc(10'h3F0, 8'h00);
    chk(32'(load_on), 32'h0);
    acc(1'b1, 10'h3F0, 8'hA5);
    rdc(10'h3F0, 8'hA5);
    acc(1'b1, 10'h3F4, 8'hAA);
    chk(32'(load_on), 32'h2A);
    rdc(10'h3F4, 8'hAA);
    chk(32'(load_on), 32'h2A);
    be <= 4'h0;
    acc(1'b1, 10'h3F4, 8'h55);
    be <= 4'h1;
    rdc(10'h3F4, 8'hAA);
    level <= 8'h0F;
    repeat (4) @(posedge clock);
    rdc(10'h3F8, 8'h55);
    acc(1'b1, 10'h3FC, 8'hFF);
    rdc(10'h3FC, 8'h55);
    level <= 8'hF0;
    repeat (4) @(posedge clock);
    rdc(10'h3FC, 8'hFF);
    acc(1'b1, 10'h3FC, 8'h0F);
    rdc(10'h3FC, 8'hFA);
    acc(1'b1, 10'h3F0, 8'h00);
    rdc(10'h3F8, 8'h0F);
    rdc(10'h3FC, 8'hFF);
    rdc(10'h1F0, 8'h00);
    acc(1'b1, 10'h1F4, 8'h7F);
    chk(32'(load_on), 32'h2A);
    io_base_select <= 5'h00;
    repeat (4) @(posedge clock);
    rdc(10'h204, 8'hAA);
    rdc(10'h3F4, 8'h00);
    summarize;
  end
endmodule
